// File: pkg/iolt_map.vh
`ifndef IOLT_MAP_VH
`define IOLT_MAP_VH

// Clock and timing.
`define IOLT_CLK_PERIOD_NS   4
`define IOLT_CLK_KHZ         250000
`define IOLT_WAKE_DET_NS     80000
`define IOLT_WAKE_DET_CYCLES (`IOLT_WAKE_DET_NS / `IOLT_CLK_PERIOD_NS)
`define IOLT_WAKE_OUT_NS     200000
`define IOLT_WAKE_OUT_CYCLES (`IOLT_WAKE_OUT_NS / `IOLT_CLK_PERIOD_NS)

// Host clock divider field codes.
`define IOLT_DIV_W           3
`define IOLT_DIV_3M686       3'h0
`define IOLT_DIV_14M74       3'h1
`define IOLT_DIV_7M37        3'h2
`define IOLT_DIV_1M843       3'h3
`define IOLT_DIV_RESET       3'h0

// Host clock frequencies in kHz and phase increments of a 32-bit accumulator.
`define IOLT_F_14M74_KHZ     64'd14740
`define IOLT_F_7M37_KHZ      64'd7370
`define IOLT_F_3M686_KHZ     64'd3686
`define IOLT_F_1M843_KHZ     64'd1843
`define IOLT_INC(f)          (((f) << 32) / 64'd250000)

// Trim field: signed, each step moves the increment by 2^TRIM_SHIFT.
`define IOLT_TRIM_W          8
`define IOLT_TRIM_SHIFT      8

// Bus mode values.
`define IOLT_MODE_SPI        1'b0
`define IOLT_MODE_I2C        1'b1

`endif

// File: rtl/iolt_buf2.v
// Two-entry buffer with valid and ready on both sides.
module iolt_buf2 #(
  parameter W = 1
) (
  // Clock and reset.
  input  wire         clk,
  input  wire         rst,
  // Filling side.
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output wire         in_ready,
  // Draining side.
  output wire         out_valid,
  output wire [W-1:0] out_data,
  input  wire         out_ready
);

  reg  [W-1:0] mem_q [0:1];
  reg          wr_q;
  reg          rd_q;
  reg  [1:0]   cnt_q;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (rst) begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

endmodule

// File: rtl/iolt_top.v
`include "iolt_map.vh"

// Behaviour
// - Valid wake-up drives wake request low 200us.
// - SPI: serial out is data, tristated when select high.
// - I2C: serial out becomes open-drain bus data.
// - I2C: fixed select/input pin levels give address.
// - Port-select low means SPI, high means I2C.
// - Receive output inverts line, direct when polarity inverted.
// - Line drives inverse of transmit, direct when inverted.
// - Driver active only with enable input and bit.
// - Host clock 3.686MHz default; divider selects others.
// - Trim field adjusts host clock frequency.
// - Line driver starts disabled after reset.
// - Opposite line level for 80us is wake-up.
// - Ignore wake-up during blanking after driven level change.
// - Interrupt output low while any status bit set.
module iolt_top #(
  parameter CW            = 17,
  parameter WAKE_DET_CYC  = `IOLT_WAKE_DET_CYCLES,
  parameter WAKE_OUT_CYC  = `IOLT_WAKE_OUT_CYCLES,
  parameter IRQ_W         = 8
) (
  // Clock and reset.
  input  wire                    clk,
  input  wire                    rst,
  // Control interface pins.
  input  wire                    port_select,
  input  wire                    sclk,
  input  wire                    select_or_addr_bit0,
  input  wire                    serial_in_or_addr_bit1,
  input  wire                    serial_out_or_bus_data_in,
  output reg                     serial_out_or_bus_data_out,
  output reg                     serial_out_or_bus_data_oe_n,
  output reg                     bus_mode_i2c,
  output reg  [1:0]              slave_addr_bits,
  // Outgoing serial bit stream from the register engine.
  input  wire                    tx_bit_valid,
  input  wire                    tx_bit,
  output wire                    tx_bit_ready,
  // UART side.
  input  wire                    uart_tx,
  input  wire                    line_drive_enable_in,
  output reg                     uart_rx,
  // Line pin.
  input  wire                    line_in,
  output reg                     line_out,
  output reg                     line_oe_n,
  // Configuration bits.
  input  wire                    line_polarity_invert,
  input  wire                    line_driver_enable_bit,
  input  wire                    wake_detect_disable,
  input  wire [CW-1:0]           blanking_cycles,
  input  wire [`IOLT_DIV_W-1:0]  host_clock_divider,
  input  wire [`IOLT_TRIM_W-1:0] host_clock_trim,
  input  wire [IRQ_W-1:0]        irq_status,
  // Status outputs.
  output reg                     wake_request_n,
  output reg                     irq_n,
  output reg                     host_clock
);

  localparam [31:0]   DET_W     = WAKE_DET_CYC;
  localparam [31:0]   OUT_W     = WAKE_OUT_CYC;
  localparam [CW-1:0] DET_MAX   = DET_W[CW-1:0];
  localparam [CW-1:0] OUT_MAX   = OUT_W[CW-1:0];
  // Phase increments are worked out wide and cut to the accumulator width.
  localparam [63:0]   INC_3M686 = `IOLT_INC(`IOLT_F_3M686_KHZ);
  localparam [63:0]   INC_14M74 = `IOLT_INC(`IOLT_F_14M74_KHZ);
  localparam [63:0]   INC_7M37  = `IOLT_INC(`IOLT_F_7M37_KHZ);
  localparam [63:0]   INC_1M843 = `IOLT_INC(`IOLT_F_1M843_KHZ);

  reg           sclk_q;
  reg  [CW-1:0] det_q;
  reg  [CW-1:0] blank_q;
  reg  [CW-1:0] wout_q;
  reg  [31:0]   acc_q;
  reg  [31:0]   inc_d;
  wire          line_out_d;
  wire          drv_on_d;
  wire          sclk_fall;
  wire          buf_valid;
  wire          buf_bit;
  wire          buf_pop;
  wire          opposite;
  wire [31:0]   trim_ext;

  // Outgoing serial bits pass a two-entry buffer so a stalled shift loses nothing.
  iolt_buf2 #(
    .W (1)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (tx_bit_valid),
    .in_data   (tx_bit),
    .in_ready  (tx_bit_ready),
    .out_valid (buf_valid),
    .out_data  (buf_bit),
    .out_ready (buf_pop)
  );

  assign sclk_fall = sclk_q & ~sclk;
  // A bit is shifted out only inside a host frame in SPI mode, or on any clock fall in I2C.
  assign buf_pop   = buf_valid & sclk_fall &
                     (bus_mode_i2c | ~select_or_addr_bit0);

  // Line path under one shared polarity setting.
  assign line_out_d = line_polarity_invert ? uart_tx : ~uart_tx;
  assign drv_on_d   = line_drive_enable_in & line_driver_enable_bit;
  assign opposite   = ~line_oe_n & (line_in != line_out);

  // Trim is signed and scaled onto the phase increment.
  assign trim_ext = {{(32-`IOLT_TRIM_W){host_clock_trim[`IOLT_TRIM_W-1]}},
                     host_clock_trim} << `IOLT_TRIM_SHIFT;

  always @* begin
    case (host_clock_divider)
      `IOLT_DIV_3M686: inc_d = INC_3M686[31:0];
      `IOLT_DIV_14M74: inc_d = INC_14M74[31:0];
      `IOLT_DIV_7M37:  inc_d = INC_7M37[31:0];
      `IOLT_DIV_1M843: inc_d = INC_1M843[31:0];
      default:         inc_d = 32'h0;
    endcase
    if (inc_d != 32'h0) begin
      inc_d = inc_d + trim_ext;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      sclk_q                      <= 1'b0;
      bus_mode_i2c                <= `IOLT_MODE_SPI;
      slave_addr_bits             <= 2'h0;
      serial_out_or_bus_data_out  <= 1'b0;
      serial_out_or_bus_data_oe_n <= 1'b1;
      uart_rx                     <= 1'b0;
      line_out                    <= 1'b0;
      line_oe_n                   <= 1'b1;
      det_q                       <= {CW{1'b0}};
      blank_q                     <= {CW{1'b0}};
      wout_q                      <= {CW{1'b0}};
      wake_request_n              <= 1'b1;
      irq_n                       <= 1'b1;
      acc_q                       <= 32'h0;
      host_clock                  <= 1'b0;
    end else begin
      sclk_q       <= sclk;
      bus_mode_i2c <= port_select;
      if (bus_mode_i2c) begin
        slave_addr_bits <= {serial_in_or_addr_bit1, select_or_addr_bit0};
      end
      // Serial output pin.
      if (bus_mode_i2c) begin
        serial_out_or_bus_data_out <= 1'b0;
        if (buf_pop) begin
          serial_out_or_bus_data_oe_n <= buf_bit;
        end
      end else begin
        if (buf_pop) begin
          serial_out_or_bus_data_out <= buf_bit;
        end
        serial_out_or_bus_data_oe_n <= select_or_addr_bit0;
      end
      // Receive and drive paths.
      uart_rx   <= line_polarity_invert ? line_in : ~line_in;
      line_out  <= line_out_d;
      line_oe_n <= ~drv_on_d;
      // Blanking restarts whenever the driven level changes.
      if (line_out_d != line_out) begin
        blank_q <= blanking_cycles;
      end else if (blank_q != {CW{1'b0}}) begin
        blank_q <= blank_q - {{(CW-1){1'b0}}, 1'b1};
      end
      // Wake-up detection on a held opposite level.
      if (!opposite || blank_q != {CW{1'b0}} || wake_detect_disable) begin
        det_q <= {CW{1'b0}};
      end else if (det_q != DET_MAX) begin
        det_q <= det_q + {{(CW-1){1'b0}}, 1'b1};
      end
      if (det_q == DET_MAX - {{(CW-1){1'b0}}, 1'b1} && opposite &&
          blank_q == {CW{1'b0}} && !wake_detect_disable && wout_q == {CW{1'b0}}) begin
        wout_q         <= OUT_MAX;
        wake_request_n <= 1'b0;
      end else if (wout_q != {CW{1'b0}}) begin
        wout_q <= wout_q - {{(CW-1){1'b0}}, 1'b1};
        if (wout_q == {{(CW-1){1'b0}}, 1'b1}) begin
          wake_request_n <= 1'b1;
        end
      end
      irq_n <= ~(|irq_status);
      // Host clock from a phase accumulator.
      if (inc_d == 32'h0) begin
        acc_q      <= 32'h0;
        host_clock <= 1'b0;
      end else begin
        acc_q      <= acc_q + inc_d;
        host_clock <= acc_q[31];
      end
    end
  end

endmodule

// File: testbench/iolt_props.sv
module iolt_props #(parameter IRQ_W = 8, parameter WAKE_OUT_CYC = 50000) (
  // Watched ports.
  input logic clk, rst, uart_tx, line_in, line_out, line_oe_n, uart_rx, irq_n,
  input logic line_polarity_invert, line_drive_enable_in, line_driver_enable_bit,
  input logic port_select, bus_mode_i2c, select_or_addr_bit0, serial_in_or_addr_bit1,
  input logic serial_out_or_bus_data_oe_n, wake_request_n,
  input logic [1:0] slave_addr_bits,
  input logic [IRQ_W-1:0] irq_status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [16:0] low_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Counts the cycles that the wake request has been low.
  always @(posedge clk) low_q <= (rst || wake_request_n) ? 17'h0 : low_q + 17'h1;
  tx_path_a: assert property (1 |=> line_out == ($past(line_polarity_invert) ~^ $past(uart_tx)))
    else $error("line level wrong");
  rx_path_a: assert property (1 |=> uart_rx == ($past(line_polarity_invert) ~^ $past(line_in)))
    else $error("receive level wrong");
  drv_enable_a: assert property (1 |=> line_oe_n == !$past(line_drive_enable_in && line_driver_enable_bit))
    else $error("driver enable wrong");
  irq_level_a: assert property (1 |=> irq_n == !(|$past(irq_status)))
    else $error("interrupt level wrong");
  mode_sel_a: assert property (1 |=> bus_mode_i2c == $past(port_select))
    else $error("bus mode wrong");
  spi_hiz_a: assert property (!port_select && $stable(port_select) && select_or_addr_bit0 && $stable(select_or_addr_bit0) |=> serial_out_or_bus_data_oe_n)
    else $error("serial out driven outside frame");
  i2c_addr_a: assert property (port_select && $past(port_select) |=> slave_addr_bits == $past({serial_in_or_addr_bit1, select_or_addr_bit0}))
    else $error("address bits wrong");
  wake_width_a: assert property ($rose(wake_request_n) |-> low_q == WAKE_OUT_CYC)
    else $error("wake pulse width wrong");
  wake_cause_a: assert property ($fell(wake_request_n) |-> !$past(line_oe_n))
    else $error("wake without driver");
endmodule
bind iolt_top iolt_props #(.IRQ_W(IRQ_W), .WAKE_OUT_CYC(WAKE_OUT_CYC)) u_props (.*);

// File: testbench/iolt_line_host.sv
module iolt_line_host (
  // Line pin and test control.
  input  logic line_out, line_oe_n, force_opp,
  output logic line_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released line floats up; a forcing master holds the opposite level.
  assign line_in = line_oe_n ? 1'b1 : (force_opp ? ~line_out : line_out);
endmodule

// File: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, ps = 0, sclk = 0, a0 = 1, a1 = 0, v = 0, b = 0, tx = 1;
  logic te = 0, en = 0, inv = 0, wdis = 0, fo = 0, lin;
  logic [16:0] blank = 0;
  logic [2:0] div = 0;
  logic [7:0] irq = 0, trim = 0;
  logic so, so_oe, i2c, rdy, rx, lo, loe, wr, irqn, hck;
  logic [1:0] addr;
  int err_total = 0, checks_done = 0, hcnt = 0;
  iolt_top #(.WAKE_DET_CYC(20), .WAKE_OUT_CYC(50)) uut (.clk(clk), .rst(rst),
    .port_select(ps), .sclk(sclk), .select_or_addr_bit0(a0), .serial_in_or_addr_bit1(a1),
    .serial_out_or_bus_data_in(so_oe ? 1'b1 : so), .serial_out_or_bus_data_out(so),
    .serial_out_or_bus_data_oe_n(so_oe), .bus_mode_i2c(i2c), .slave_addr_bits(addr),
    .tx_bit_valid(v), .tx_bit(b), .tx_bit_ready(rdy), .uart_tx(tx),
    .line_drive_enable_in(te), .uart_rx(rx), .line_in(lin), .line_out(lo), .line_oe_n(loe),
    .line_polarity_invert(inv), .line_driver_enable_bit(en), .wake_detect_disable(wdis),
    .blanking_cycles(blank), .host_clock_divider(div), .host_clock_trim(trim),
    .irq_status(irq), .wake_request_n(wr), .irq_n(irqn), .host_clock(hck));
  iolt_line_host host (.line_out(lo), .line_oe_n(loe), .force_opp(fo), .line_in(lin));
  initial forever #2 clk = ~clk;
  always @(posedge hck) hcnt++;
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      err_total++;
      $display("Error %0t %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task t_paths;
    wdis = 1; te = 1; en = 1;
    for (int i = 0; i < 8; i++) begin
      {inv, tx, fo} = i[2:0];
      cyc(3);
      chk(lo === (inv ~^ tx), "tx path");
      chk(rx === (inv ~^ (fo ^ (inv ~^ tx))), "rx path");
    end
    for (int i = 0; i < 4; i++) begin
      {te, en} = i[1:0];
      cyc(2);
      chk(loe === ~(te & en), "driver enable");
    end
    for (int i = 0; i < 9; i++) begin
      irq = 8'h01 << i;
      cyc(2);
      chk(irqn === ~|irq, "irq level");
    end
  endtask
  task t_wake;
    int n;
    wdis = 0; fo = 0; inv = 0; cyc(3);
    fo = 1; cyc(10); fo = 0; cyc(40);
    chk(wr === 1'b1, "short hold woke");
    fo = 1; n = 0;
    while (wr !== 1'b0 && n < 40) begin cyc(1); n++; end
    chk(n >= 19 && n <= 22, "wake delay");
    fo = 0; n = 0;
    while (wr === 1'b0 && n < 60) begin cyc(1); n++; end
    chk(n == 50, "wake width");
    blank = 17'd200; tx = ~tx; cyc(2); fo = 1; cyc(60);
    chk(wr === 1'b1, "wake in blanking");
    fo = 0; blank = 0;
  endtask
  task pop;
    sclk = 1; cyc(1); sclk = 0; cyc(2);
  endtask
  task t_spi;
    ps = 0; a0 = 1; cyc(2);
    v = 1; b = 1; cyc(1); b = 0; cyc(1); v = 0;
    chk(rdy === 1'b0, "buffer full");
    pop; cyc(1);
    chk(so_oe === 1'b1 && rdy === 1'b0, "pop outside frame");
    a0 = 0; cyc(2); pop;
    chk(so === 1'b1 && so_oe === 1'b0 && rdy === 1'b1, "first bit");
    pop;
    chk(so === 1'b0, "second bit");
    a0 = 1; cyc(2);
    chk(so_oe === 1'b1, "not released");
  endtask
  task t_i2c;
    ps = 1; a1 = 1; a0 = 0; cyc(3);
    chk(i2c === 1'b1 && addr === 2'b10, "address 2");
    a1 = 0; a0 = 1; cyc(3);
    chk(addr === 2'b01, "address 1");
    v = 1; b = 0; cyc(1); b = 1; cyc(1); v = 0; pop;
    chk(so_oe === 1'b0 && so === 1'b0, "bus data low");
    pop;
    chk(so_oe === 1'b1, "bus data released");
    ps = 0; cyc(2);
    chk(i2c === 1'b0, "back to spi");
  endtask
  task t_clk;
    int f [5] = '{3686, 14740, 7370, 1843, 0};
    int e;
    for (int d = 0; d < 5; d++) begin
      div = d[2:0]; cyc(4); hcnt = 0; cyc(2000);
      e = f[d] * 2000 / 250000;
      chk(hcnt + 1 >= e && hcnt <= e + 2, "host clock rate");
    end
  endtask
  task t_trim;
    int n [3];
    logic [7:0] tv [3] = '{8'h00, 8'h7f, 8'h80};
    for (int k = 0; k < 3; k++) begin
      div = 3'h4; trim = tv[k]; cyc(2);
      div = 3'h1; hcnt = 0; n[k] = 0;
      while (hcnt < 1200 && n[k] < 30000) begin cyc(1); n[k]++; end
    end
    div = 3'h4; trim = 8'h00;
    chk(n[0] >= 20340 && n[0] <= 20350, "untrimmed rate");
    chk(n[1] < n[0] && n[2] > n[0], "trim direction");
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    cyc(3); rst = 0;
    chk(loe === 1'b1 && wr === 1'b1 && irqn === 1'b1 && rdy === 1'b1, "reset");
    t_paths; $display("paths done");
    t_wake; $display("wake done");
    t_spi; $display("spi done");
    t_i2c; $display("i2c done");
    t_clk; $display("clock done");
    t_trim; $display("trim done");
    summarize;
  end
  initial begin
    #400us;
    err_total++;
    summarize;
  end
endmodule
